// *** common/sar_adc_consts.svh ***
// Behaviour
// RL1: Ten-bit successive approximation result into result pair
// RL2: Channel field steers shared sample-and-hold input
// RL3: Software waits settling time after channel change
// RL4: Reference bit picks supply or pin; negative grounded
// RL5: Clock select picks divisor or RC clock
// RL6: One bit period per bit, eleven per conversion
// RL7: Software avoids too-short bit periods
// RL8: Divided bit periods follow the system clock
// RL9: RC bit period independent of system clock
// RL10: RC clock advised only for sleep conversions
// RL11: Completion flag set after every conversion
// RL12: Software clears completion flag itself
// RL13: Interrupt when flag and enable both set
// RL14: Interrupt in run and sleep; wakes sleep
// RL15: Wake resumes at instruction after sleep
// RL16: Branch to handler only with global enable
// RL17: Software sets pin input and analog select
// RL18: Start bit write with converter on starts
// RL19: Completion clears busy, sets flag, loads result
// RL20: Abort keeps old result; two-period restart delay
// RL21: Format bit justifies result left or right
// RL22: Bits resolved nine down to zero
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH
// Register word indices, byte address is index times four
`define IDX_CONTROL0      3'h0
`define IDX_CONTROL1      3'h1
`define IDX_RESULT_HIGH   3'h2
`define IDX_RESULT_LOW    3'h3
`define IDX_ANALOG_SEL    3'h4
`define IDX_IRQ_ENABLE    3'h5
`define IDX_IRQ_FLAGS     3'h6
`define IDX_CORE_IRQ      3'h7
// Field positions
`define BIT_JUSTIFY       7
`define BIT_POSREF        6
`define BIT_CHAN_HI       4
`define BIT_CHAN_LO       2
`define BIT_START         1
`define BIT_ON            0
`define BIT_CLK_HI        6
`define BIT_CLK_LO        4
`define BIT_CONV_IRQ      6
`define BIT_GLOBAL_IRQ    0
// Reset values
`define RST_CONTROL0      8'h00
`define RST_CONTROL1      8'h00
`define RST_ANALOG_SEL    8'hFF
`define RST_IRQ_ENABLE    8'h00
`define RST_IRQ_FLAGS     8'h00
`define RST_CORE_IRQ      8'h00
// Conversion timing in bit periods, and the first trial code
`define TAD_LAST          4'hA
`define ABORT_LAST        4'h1
`define SAR_FIRST_TRIAL   10'h200
`endif

// *** common/sar_adc_pkg.sv ***
package sar_adc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_ABORT
  } conv_state_t;

  // Controls toward the analog multiplexer and converter core
  typedef struct packed {
    logic [2:0] channel_select;
    logic       positive_reference_select;
    logic       sample;
    logic [9:0] trial;
  } ana_ctrl_t;
endpackage

// *** rtl/sar_adc_control.sv ***
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "sar_adc_consts.svh"
module sar_adc_control (
  input  wire logic                    clk,          // 40 MHz system clock
  input  wire logic                    srst,         // Synchronous reset
  input  wire logic                    ce,           // Clock enable, freezes all
  input  wire logic                    hsel,         // Slave select
  input  wire logic [31:0]             haddr,        // Byte address
  input  wire logic [1:0]              htrans,       // Transfer type
  input  wire logic                    hwrite,       // Write when high
  input  wire logic [2:0]              hsize,        // Word only
  input  wire logic [31:0]             hwdata,       // Write data
  input  wire logic                    hready,       // Bus ready
  input  wire logic                    comp_pin,     // High: input below trial
  input  wire logic                    frc_pin,      // Dedicated RC oscillator
  input  wire logic                    sleep_mode,   // Core is sleeping
  output logic                         hreadyout_q,  // Slave ready
  output logic [31:0]                  hrdata_q,     // Read data
  output logic                         hresp_q,      // Always OKAY
  output sar_adc_pkg::ana_ctrl_t       ana_q,        // Analog side controls
  output logic [7:0]                   analog_pin_q, // Analog pin select
  output logic                         irq_q,        // Conversion interrupt
  output logic                         wake_q,       // Wake, resume next instr
  output logic                         isr_branch_q  // Branch to handler
);
  import sar_adc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  conv_state_t  state_q;
  logic [7:0]   control0_q, control1_q, result_high_q, result_low_q;
  logic [7:0]   analog_input_select_q, peripheral_irq_enable_one_q;
  logic [7:0]   peripheral_irq_flags_one_q, core_irq_q;
  logic [9:0]   sar_q, sar_d;
  logic [3:0]   tad_cnt_q, bit_idx;
  logic [5:0]   div_cnt_q, div_last;
  logic [2:0]   sync_q [2];
  logic [1:0]   lvl_q;
  logic         frc_prev_q, rc_mode, rc_rise, tick, running;
  logic         wr_pend_q, rd_pend_q, map_wr_q, map_rd_q;
  logic [2:0]   wr_idx_q, rd_idx_q;
  logic         wr_en, sw_start, sw_stop, abort_req, done, addr_ok;
  logic         irq_pend;

  // Last count of the system clock divider for a clock select code
  function automatic logic [5:0] divider_last(input logic [2:0] sel);
    logic [2:0] idx;
    idx = {sel[1:0], sel[2]};
    divider_last = 6'((7'h02 << idx) - 7'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, a change counts once stages two and three agree
  wire logic [1:0] pins = {frc_pin, comp_pin};
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sync_q[i] <= 3'h0;
          lvl_q[i]  <= 1'b0;
        end else if (ce) begin
          sync_q[i] <= {sync_q[i][1:0], pins[i]};
          if (sync_q[i][1] == sync_q[i][2]) begin
            lvl_q[i] <= sync_q[i][2];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bit period tick: divided system clock or RC oscillator edges
  assign rc_mode  = (control1_q[`BIT_CLK_LO +: 2] == 2'h3);                // [RL5]
  assign div_last = divider_last(control1_q[`BIT_CLK_HI:`BIT_CLK_LO]);     // [RL5]
  assign rc_rise  = lvl_q[1] & ~frc_prev_q;                                // [RL9]
  assign running  = (state_q != ST_IDLE);
  assign tick     = rc_mode ? rc_rise : (running && div_cnt_q >= div_last); // [RL8]

  // Divider restarts with every conversion so the first period is whole
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_q  <= 6'h00;
      frc_prev_q <= 1'b0;
    end else if (ce) begin
      frc_prev_q <= lvl_q[1];
      if (!running || div_cnt_q >= div_last) begin
        div_cnt_q <= 6'h00;
      end else begin
        div_cnt_q <= div_cnt_q + 6'h01;                                    // [RL8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture; writes land in the data phase
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_en   = wr_pend_q & map_wr_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      map_wr_q    <= 1'b0;
      map_rd_q    <= 1'b0;
      wr_idx_q    <= 3'h0;
      rd_idx_q    <= 3'h0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (ce) begin
      wr_pend_q   <= addr_ok & hwrite;
      rd_pend_q   <= addr_ok & ~hwrite;
      map_wr_q    <= (haddr[31:5] == 27'h0);
      map_rd_q    <= (haddr[31:5] == 27'h0);
      wr_idx_q    <= haddr[4:2];
      rd_idx_q    <= haddr[4:2];
      // One wait state on reads so a write just before is visible
      hreadyout_q <= ~(addr_ok & ~hwrite);
    end
  end

  // Read data, unmapped words read as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && rd_pend_q) begin
      hrdata_q <= 32'h0000_0000;
      if (map_rd_q) begin
        case (rd_idx_q)
          `IDX_CONTROL0:    hrdata_q[7:0] <= control0_q | {6'h00, state_q == ST_CONV, 1'b0};
          `IDX_CONTROL1:    hrdata_q[7:0] <= control1_q;
          `IDX_RESULT_HIGH: hrdata_q[7:0] <= result_high_q;
          `IDX_RESULT_LOW:  hrdata_q[7:0] <= result_low_q;
          `IDX_ANALOG_SEL:  hrdata_q[7:0] <= analog_input_select_q;
          `IDX_IRQ_ENABLE:  hrdata_q[7:0] <= peripheral_irq_enable_one_q;
          `IDX_IRQ_FLAGS:   hrdata_q[7:0] <= peripheral_irq_flags_one_q;
          default:          hrdata_q[7:0] <= core_irq_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; busy is the state itself, not stored here
  always_ff @(posedge clk) begin
    if (srst) begin
      control0_q                  <= `RST_CONTROL0;
      control1_q                  <= `RST_CONTROL1;
      analog_input_select_q       <= `RST_ANALOG_SEL;
      peripheral_irq_enable_one_q <= `RST_IRQ_ENABLE;
      core_irq_q                  <= `RST_CORE_IRQ;
    end else if (ce && wr_en) begin
      case (wr_idx_q)
        `IDX_CONTROL0:   control0_q <= hwdata[7:0] & 8'hDD;
        `IDX_CONTROL1:   control1_q <= hwdata[7:0] & 8'h70;
        `IDX_ANALOG_SEL: analog_input_select_q <= hwdata[7:0];               // [RL17]
        `IDX_IRQ_ENABLE: peripheral_irq_enable_one_q <= hwdata[7:0];
        `IDX_CORE_IRQ:   core_irq_q <= hwdata[7:0] & 8'h01;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, stop and abort conditions
  wire logic ctl0_wr = wr_en && (wr_idx_q == `IDX_CONTROL0);
  assign sw_start  = ctl0_wr && hwdata[`BIT_START] && control0_q[`BIT_ON]; // [RL18]
  assign sw_stop   = ctl0_wr && (!hwdata[`BIT_START] || !hwdata[`BIT_ON]); // [RL20]
  // Sleep kills a conversion unless it runs on the RC clock
  assign abort_req = sw_stop || (sleep_mode && !rc_mode);
  assign done      = (state_q == ST_CONV) && tick && (tad_cnt_q == `TAD_LAST)
                     && !abort_req;                                        // [RL6]

  // Successive approximation step, MSB first after the first period
  assign bit_idx = 4'hA - tad_cnt_q;                                       // [RL22]
  always_comb begin
    sar_d = sar_q;
    if (tad_cnt_q != 4'h0) begin
      if (lvl_q[0]) begin
        sar_d[bit_idx] = 1'b0;                                             // [RL22]
      end
      if (bit_idx != 4'h0) begin
        sar_d[bit_idx - 4'h1] = 1'b1;                                      // [RL22]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q   <= ST_IDLE;
      tad_cnt_q <= 4'h0;
      sar_q     <= 10'h000;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (sw_start && !(sleep_mode && !rc_mode)) begin
            state_q   <= ST_CONV;                                          // [RL18]
            tad_cnt_q <= 4'h0;
            sar_q     <= `SAR_FIRST_TRIAL;
          end
        end
        ST_CONV: begin
          if (abort_req) begin
            state_q   <= ST_ABORT;                                         // [RL20]
            tad_cnt_q <= 4'h0;
          end else if (tick) begin
            sar_q     <= sar_d;
            tad_cnt_q <= tad_cnt_q + 4'h1;                                 // [RL6]
            if (tad_cnt_q == `TAD_LAST) begin
              state_q <= ST_IDLE;                                          // [RL19]
            end
          end
        end
        ST_ABORT: begin
          if (tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
            if (tad_cnt_q == `ABORT_LAST) begin
              state_q <= ST_IDLE;                                          // [RL20]
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result pair loads only on completion, formatted at load time
  always_ff @(posedge clk) begin
    if (srst) begin
      result_high_q <= 8'h00;
      result_low_q  <= 8'h00;
    end else if (ce && done) begin
      if (control0_q[`BIT_JUSTIFY]) begin
        result_high_q <= {6'h00, sar_d[9:8]};                              // [RL21]
        result_low_q  <= sar_d[7:0];                                       // [RL1]
      end else begin
        result_high_q <= sar_d[9:2];                                       // [RL21]
        result_low_q  <= {sar_d[1:0], 6'h00};
      end
    end
  end

  // Flags; a completion in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (srst) begin
      peripheral_irq_flags_one_q <= `RST_IRQ_FLAGS;
    end else if (ce) begin
      if (wr_en && wr_idx_q == `IDX_IRQ_FLAGS) begin
        peripheral_irq_flags_one_q <= hwdata[7:0];                         // [RL12]
      end
      if (done) begin
        peripheral_irq_flags_one_q[`BIT_CONV_IRQ] <= 1'b1;                 // [RL11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, wake and branch outputs toward the core
  assign irq_pend = peripheral_irq_flags_one_q[`BIT_CONV_IRQ]
                    & peripheral_irq_enable_one_q[`BIT_CONV_IRQ];          // [RL13]
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q        <= 1'b0;
      wake_q       <= 1'b0;
      isr_branch_q <= 1'b0;
    end else if (ce) begin
      irq_q        <= irq_pend;                                            // [RL14]
      wake_q       <= irq_pend & sleep_mode;                               // [RL15]
      isr_branch_q <= irq_pend & core_irq_q[`BIT_GLOBAL_IRQ];              // [RL16]
    end
  end

  // Analog controls; sampling only while idle and switched on
  always_ff @(posedge clk) begin
    if (srst) begin
      ana_q        <= '0;
      analog_pin_q <= `RST_ANALOG_SEL;
    end else if (ce) begin
      ana_q.channel_select            <= control0_q[`BIT_CHAN_HI:`BIT_CHAN_LO]; // [RL2]
      ana_q.positive_reference_select <= control0_q[`BIT_POSREF];          // [RL4]
      ana_q.sample  <= (state_q == ST_IDLE) && control0_q[`BIT_ON];
      ana_q.trial   <= (state_q == ST_CONV) ? sar_q : 10'h000;
      analog_pin_q  <= analog_input_select_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  done_sets_flag_a: assert property (@(posedge clk) disable iff (srst)  // [RL11]
    ce && done |=> peripheral_irq_flags_one_q[`BIT_CONV_IRQ] && state_q == ST_IDLE)
    else $error("completion did not set flag or clear busy");
  abort_keeps_a: assert property (@(posedge clk) disable iff (srst)  // [RL20]
    state_q == ST_ABORT |-> $stable(result_high_q) && $stable(result_low_q))
    else $error("result changed after abort");
  abort_two_a: assert property (@(posedge clk) disable iff (srst)  // [RL20]
    state_q == ST_ABORT |-> tad_cnt_q <= `ABORT_LAST)
    else $error("abort wait exceeded two periods");
  start_begins_a: assert property (@(posedge clk) disable iff (srst)  // [RL18]
    ce && sw_start && state_q == ST_IDLE && !sleep_mode |=> state_q == ST_CONV && tad_cnt_q == 4'h0)
    else $error("start did not begin conversion");
  eleven_periods_a: assert property (@(posedge clk) disable iff (srst)  // [RL6]
    state_q == ST_CONV |-> tad_cnt_q <= `TAD_LAST)
    else $error("conversion ran past eleven periods");
  divider_tick_a: assert property (@(posedge clk) disable iff (srst)  // [RL5]
    tick && !rc_mode |-> div_cnt_q == divider_last(control1_q[6:4]))
    else $error("divided tick at wrong count");
  irq_follows_a: assert property (@(posedge clk) disable iff (srst)  // [RL13]
    ce |=> irq_q == $past(irq_pend))
    else $error("interrupt does not follow flag and enable");
  branch_gate_a: assert property (@(posedge clk) disable iff (srst)  // [RL16]
    ce && irq_pend && !core_irq_q[0] |=> !isr_branch_q)
    else $error("branch without global enable");
  wake_sleep_a: assert property (@(posedge clk) disable iff (srst)  // [RL14]
    ce && irq_pend && sleep_mode |=> wake_q ##0 irq_q)
    else $error("interrupt in sleep did not wake");
  msb_first_a: assert property (@(posedge clk) disable iff (srst)  // [RL22]
    ce && state_q == ST_IDLE && sw_start && !sleep_mode |=> sar_q == 10'h200)
    else $error("first trial not bit nine");
endmodule

// *** verification/sar_adc_analog_model.sv ***
`timescale 1ns/10ps
module sar_adc_analog_model (
  input  wire logic                   clk,      // System clock
  input  wire sar_adc_pkg::ana_ctrl_t ana,      // Controls from the block
  output logic                        comp_pin, // Comparator decision
  output logic                        frc_pin   // Dedicated RC oscillator
);
  import sar_adc_pkg::*;
  localparam realtime FRC_HALF = 100ns;

  logic [9:0] held_q = 10'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold capacitor follows the routed input while sampling, frozen otherwise
  always @(posedge clk) begin
    if (ana.sample) begin
      held_q <= ana.positive_reference_select ? {ana.channel_select, 7'h55}
                                              : {~ana.channel_select, 7'h2A};
    end
  end

  // Comparator is asynchronous; the block syncs it, so no edge alignment here
  assign comp_pin = (held_q < ana.trial);

  // RC oscillator runs free, unrelated to the system clock
  initial begin
    frc_pin = 1'b0;
    forever #(FRC_HALF) frc_pin = ~frc_pin;
  end
endmodule

// *** verification/sar_adc_control_tb.sv ***
`timescale 1ns/10ps
`include "sar_adc_consts.svh"
module sar_adc_control_tb;
  import sar_adc_pkg::*;
  localparam int LIMIT = 20000;

  logic        clk, srst, ce, hsel, hwrite, sleep_mode, comp_pin, frc_pin;
  logic [9:0]  t;
  logic        hreadyout_q, hresp_q, irq_q, wake_q, isr_branch_q;
  logic [31:0] haddr, hwdata, hrdata_q;
  logic [1:0]  htrans;
  logic [7:0]  analog_pin_q, v;
  ana_ctrl_t   ana;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  logic [2:0]  sels [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
  int          divs [6] = '{2, 4, 8, 16, 32, 64};

  sar_adc_control sar_adc_control_i (
    .clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout_q),
    .comp_pin(comp_pin), .frc_pin(frc_pin), .sleep_mode(sleep_mode),
    .hreadyout_q(hreadyout_q), .hrdata_q(hrdata_q), .hresp_q(hresp_q), .ana_q(ana),
    .analog_pin_q(analog_pin_q), .irq_q(irq_q), .wake_q(wake_q), .isr_branch_q(isr_branch_q)
  );

  sar_adc_analog_model sar_adc_analog_model_i (
    .clk(clk), .ana(ana), .comp_pin(comp_pin), .frc_pin(frc_pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus access, single word transfers
  function automatic logic [31:0] adr(input logic [2:0] idx);
    return {27'h0, idx, 2'b00};
  endfunction

  function automatic logic [9:0] code(input logic [2:0] ch, input logic ref_sel);
    return ref_sel ? {ch, 7'h55} : {~ch, 7'h2A};
  endfunction

  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] wd,
                     output logic [7:0] rdv);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout_q !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout_q !== 1'b1);
    rdv = hrdata_q[7:0];
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask

  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    bus(a, 1'b0, 8'h00, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi, input string what);
    checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask

  // Result pair read back in the chosen justification
  task automatic res(input logic [9:0] r, input logic right);
    logic [7:0] h, l;
    rd(adr(`IDX_RESULT_HIGH), h);
    rd(adr(`IDX_RESULT_LOW), l);
    chk(h, right ? {6'h00, r[9:8]} : r[9:2], "result high");
    chk(l, right ? r[7:0] : {r[1:0], 6'h00}, "result low");
  endtask

  // Start a conversion and count cycles until sampling resumes
  task automatic conv(input logic [7:0] ctl, output int cnt);
    int k;
    wr(adr(`IDX_CONTROL0), ctl | 8'h02);
    k = 0;
    while (ana.sample === 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(ana.channel_select, ctl[4:2], "channel routed");
    chk(ana.positive_reference_select, ctl[6], "reference routed");
    cnt = k;
    while (ana.sample !== 1'b1 && cnt < 3000) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hwdata = 32'h0; sleep_mode = 1'b0; ce = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // Reset values, then an unmapped word
    for (int i = 0; i < 8; i++) begin
      rd(adr(i[2:0]), v);
      chk(v, (i == 4) ? 8'hFF : 8'h00, "reset value");
    end
    chk(analog_pin_q, 8'hFF, "analog pins after reset");
    wr(32'h20, 8'h55);
    rd(32'h20, v);
    chk(v, 8'h00, "unmapped read");
    chk(hresp_q, 1'b0, "response");
    wr(adr(`IDX_ANALOG_SEL), 8'h68);
    // Register copy reaches the pins one clock after the write lands
    repeat (2) @(posedge clk);
    chk(analog_pin_q, 8'h68, "analog pin select");
    // Start with the converter off is ignored
    wr(adr(`IDX_CONTROL0), 8'h02);
    rd(adr(`IDX_CONTROL0), v);
    chk(v, 8'h00, "start while off");
    // Every divisor: length, busy clear, flag without interrupt
    for (int i = 0; i < 6; i++) begin
      wr(adr(`IDX_CONTROL1), {1'b0, sels[i], 4'h0});
      wr(adr(`IDX_CONTROL0), 8'h8D);
      repeat (20) @(posedge clk);
      conv(8'h8D, n);
      chk_span(n, 10 * divs[i] + 1, 11 * divs[i] + 4, "conversion");
      rd(adr(`IDX_CONTROL0), v);
      chk(v, 8'h8D, "busy cleared");
      if (divs[i] >= 8) res(code(3'd3, 1'b0), 1'b1);
      rd(adr(`IDX_IRQ_FLAGS), v);
      chk(v[6], 1'b1, "done flag");
      chk(irq_q, 1'b0, "masked request");
      if (i < 5) wr(adr(`IDX_IRQ_FLAGS), 8'h00);
    end
    // Left justified, external reference
    wr(adr(`IDX_CONTROL1), 8'h10);
    wr(adr(`IDX_CONTROL0), 8'h55);
    repeat (20) @(posedge clk);
    conv(8'h55, n);
    res(code(3'd5, 1'b1), 1'b0);
    // Interrupt enable, global branch and flag clear
    wr(adr(`IDX_IRQ_ENABLE), 8'h40);
    repeat (2) @(posedge clk);
    chk(irq_q, 1'b1, "request");
    chk(isr_branch_q, 1'b0, "no branch while global off");
    chk(wake_q, 1'b0, "no wake while running");
    wr(adr(`IDX_CORE_IRQ), 8'h01);
    repeat (2) @(posedge clk);
    chk(isr_branch_q, 1'b1, "branch");
    wr(adr(`IDX_CORE_IRQ), 8'h00);
    wr(adr(`IDX_IRQ_FLAGS), 8'h00);
    repeat (2) @(posedge clk);
    chk(irq_q, 1'b0, "request cleared");
    // RC clock conversion in sleep wakes the core
    wr(adr(`IDX_CONTROL1), 8'h30);
    wr(adr(`IDX_CONTROL0), 8'hD9);
    repeat (20) @(posedge clk);
    sleep_mode <= 1'b1;
    conv(8'hD9, n);
    chk_span(n, 80, 100, "RC conversion");
    repeat (2) @(posedge clk);
    chk(wake_q, 1'b1, "wake");
    chk(irq_q, 1'b1, "request in sleep");
    sleep_mode <= 1'b0;
    res(code(3'd6, 1'b1), 1'b1);
    // Abort mid-conversion keeps the old result
    wr(adr(`IDX_IRQ_FLAGS), 8'h00);
    wr(adr(`IDX_CONTROL1), 8'h60);
    wr(adr(`IDX_CONTROL0), 8'h85);
    repeat (20) @(posedge clk);
    wr(adr(`IDX_CONTROL0), 8'h87);
    repeat (100) @(posedge clk);
    // Clock enable low freezes the running conversion
    ce <= 1'b0;
    @(posedge clk);
    t = ana.trial;
    repeat (100) @(posedge clk);
    chk(ana.trial, t, "frozen by clock enable");
    ce <= 1'b1;
    repeat (100) @(posedge clk);
    wr(adr(`IDX_CONTROL0), 8'h85);
    n = 0;
    while (ana.sample !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk_span(n, 64, 132, "abort dead time");
    res(code(3'd6, 1'b1), 1'b1);
    // Sleep on a divided clock aborts the same way
    wr(adr(`IDX_CONTROL0), 8'h87);
    repeat (100) @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (300) @(posedge clk);
    sleep_mode <= 1'b0;
    rd(adr(`IDX_CONTROL0), v);
    chk(v, 8'h85, "sleep abort clears busy");
    res(code(3'd6, 1'b1), 1'b1);
    rd(adr(`IDX_IRQ_FLAGS), v);
    chk(v, 8'h00, "no flag on abort");
    test_done();
  end
endmodule
